//--- bench/rtm_ram_model.sv
`timescale 1ns/100ps
module rtm_ram_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] stall,
  input wire logic ram_re,
  input wire logic ram_we,
  input wire logic [12:0] ram_addr,
  input wire logic [15:0] ram_wdata,
  output logic [15:0] ram_rdata,
  input wire logic tx_valid,
  input wire logic [15:0] tx_data,
  output logic tx_ready
);
  logic [15:0] mem [0:8191];
  logic [3:0] wcnt;
  logic [15:0] tx_seen;
  int n_tx;
  int n_wr;
  // Read data lasts one cycle, then the bus shows changing junk.
  // The encoder takes a word after a programmable stall.
  always @(posedge clk) begin
    if (reset) begin
      ram_rdata <= 16'h0000;
      tx_ready <= 1'b0;
      wcnt <= 4'h0;
      n_tx <= 0;
      n_wr <= 0;
    end else begin
      ram_rdata <= ram_re ? mem[ram_addr] : ~ram_rdata;
      if (ram_we) begin
        mem[ram_addr] <= ram_wdata;
        n_wr <= n_wr + 1;
      end
      if (tx_valid && tx_ready) begin
        n_tx <= n_tx + 1;
        tx_seen <= tx_data;
      end
      tx_ready <= tx_valid && !tx_ready && wcnt >= stall;
      wcnt <= (tx_valid && !tx_ready) ? wcnt + 4'h1 : 4'h0;
    end
  end
endmodule

//--- bench/rtm_record_test.sv
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin \
  compares++; \
  if ((gt) !== (ex)) begin \
    n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, gt); \
  end \
end
module rtm_record_test;
  import rtm_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce_in = 1'b1;
  logic cmd_valid = 1'b0;
  logic [15:0] cmd_word = 16'h0000;
  logic [6:0] fl = 7'h00;
  logic [12:0] data_ptr = 13'h0000;
  logic gap_pin = 1'b0;
  logic resp = 1'b0;
  logic extra = 1'b0;
  logic done = 1'b0;
  logic [15:0] tt_in = 16'h0000;
  logic [3:0] stall = 4'h0;
  logic tx_valid, tx_ready, ram_re, ram_we, active, record_done;
  logic [15:0] tx_data, ram_rdata, ram_wdata;
  logic [12:0] ram_addr;
  logic [4:0] ud [4] = '{MC_UNDEF_A, MC_UNDEF_B, MC_UNDEF_C, 5'h16};
  int compares = 0;
  int n_mismatch = 0;
  int idx = 0;

  rtm_record u_dut (
    .clk(clk), .reset(reset), .ce(ce_in), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .cmd_broadcast(fl[1]), .cmd_bus_b(fl[0]),
    .data_ptr(data_ptr), .global_busy(fl[2]), .per_command_busy(fl[3]),
    .illegal_bit(fl[4]), .undefined_mode_code_invalidate(fl[5]),
    .gap_means_broadcast(fl[6]), .bus_activity_pin(gap_pin),
    .response_start(resp), .extra_word(extra), .msg_done(done),
    .last_command(16'h4a52), .bit_word(16'h00c3), .time_tag(tt_in),
    .tx_ready(tx_ready), .ram_rdata(ram_rdata), .tx_valid(tx_valid),
    .tx_data(tx_data), .ram_re(ram_re), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .active(active),
    .record_done(record_done)
  );

  rtm_ram_model u_ram (
    .clk(clk), .reset(reset), .stall(stall), .ram_re(ram_re),
    .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready)
  );

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Flags f: 0 bus B, 1 broadcast, 2 global busy, 3 command busy,
  // 4 illegal, 5 invalidate, 6 broadcast meaning, 7 gap, 8 extra word.
  task automatic run_cmd(input logic [4:0] mc, input logic [8:0] f,
      input logic exp_tx);
    logic [12:0] ptr;
    logic [15:0] pre, tt, xw, miw, sl;
    logic g13, e10, wr3;
    int nt, nw, n;
    ptr = 13'h1000 + 13'(idx * 4);
    pre = 16'h5a00 + 16'(idx);
    tt = 16'h7100 + 16'(idx);
    xw = mc == MC_LAST_CMD ? 16'h4a52 : mc == MC_BIT_WORD ? 16'h00c3 : pre;
    g13 = f[6] ? f[1] : f[7];
    e10 = f[8] | (g13 & ~f[6]);
    miw = {2'b00, g13, f[8], 1'b0, e10, f[2] | f[3], f[4], 2'b00, f[0], mc};
    wr3 = exp_tx && (mc == MC_LAST_CMD || mc == MC_BIT_WORD);
    sl = wr3 ? xw : pre;
    u_ram.mem[ptr + 13'h0002] = pre;
    nt = u_ram.n_tx;
    nw = u_ram.n_wr;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_word <= {5'h05, 1'b1, mc[0] ? 5'h00 : 5'h1f, mc};
    fl <= f[6:0];
    data_ptr <= ptr;
    stall <= 4'(idx % 4);
    @(posedge clk);
    cmd_valid <= 1'b0;
    gap_pin <= f[7];
    extra <= f[8];
    @(posedge clk);
    extra <= 1'b0;
    repeat (5) @(posedge clk);
    gap_pin <= 1'b0;
    resp <= 1'b1;
    @(posedge clk);
    resp <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    `CHK("early writes", nw, u_ram.n_wr)
    @(posedge clk);
    done <= 1'b1;
    tt_in <= tt;
    @(posedge clk);
    done <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (record_done !== 1'b1 && n < 20);
    `CHK("record_done", 1'b1, record_done)
    repeat (2) @(posedge clk);
    #1;
    `CHK("tx count", nt + int'(exp_tx), u_ram.n_tx)
    if (exp_tx) `CHK("tx word", xw, u_ram.tx_seen)
    `CHK("info word", miw, u_ram.mem[ptr])
    `CHK("time tag", tt, u_ram.mem[ptr + 13'h1])
    `CHK("data slot", sl, u_ram.mem[ptr + 13'h2])
    `CHK("writes", nw + (wr3 ? 3 : 2), u_ram.n_wr)
    `CHK("active", 1'b0, active)
    idx++;
  endtask

  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    for (int m = 16; m < 32; m++) begin
      run_cmd(5'(m), 9'(m & 1), 1'b1);
    end
    $display("test data codes done");
    for (int m = 0; m < 16; m++) begin
      run_cmd(5'(m), 9'(m & 1), 1'b0);
    end
    $display("test no-data codes done");
    foreach (ud[i]) begin
      run_cmd(ud[i], 9'h020, ud[i] == 5'h16);
    end
    $display("test invalidate done");
    run_cmd(5'h10, 9'h004, 1'b0);
    run_cmd(MC_BIT_WORD, 9'h008, 1'b0);
    $display("test busy done");
    run_cmd(5'h10, 9'h010, 1'b0);
    run_cmd(5'h03, 9'h011, 1'b0);
    $display("test illegal done");
    run_cmd(5'h01, 9'h080, 1'b0);
    run_cmd(5'h01, 9'h042, 1'b0);
    run_cmd(5'h12, 9'h0c0, 1'b1);
    $display("test gap and broadcast done");
    run_cmd(5'h02, 9'h100, 1'b0);
    run_cmd(MC_LAST_CMD, 9'h180, 1'b1);
    $display("test word count done");
    @(posedge clk);
    ce_in <= 1'b0;
    cmd_valid <= 1'b1;
    cmd_word <= {5'h05, 1'b1, 5'h00, 5'h10};
    @(posedge clk);
    ce_in <= 1'b1;
    cmd_word <= {5'h05, 1'b0, 5'h00, 5'h10};
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    `CHK("ignored command", 1'b0, active)
    $display("test ignored commands done");
    summarize();
  end
endmodule

//--- verilog/rtm_miw_build.sv
`timescale 1ns/100ps
module rtm_miw_build (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic load,
  input wire logic gap_err,
  input wire logic broadcast,
  input wire logic gap_means_broadcast,
  input wire logic word_count_error,
  input wire logic replied_busy_flag,
  input wire logic illegal_command_flag,
  input wire logic bus_select_flag,
  input wire logic [rtm_pkg::MC_W-1:0] mode_code_field,
  output logic [rtm_pkg::WORD_W-1:0] miw
);
  import rtm_pkg::*;
  logic [WORD_W-1:0] miw_ff;
  logic [WORD_W-1:0] nxt_miw;
  logic gap_or_broadcast_flag;
  logic message_error_summary;

  always_comb begin
    gap_or_broadcast_flag = gap_means_broadcast ? broadcast
      : gap_err;
    message_error_summary = word_count_error
      | (gap_err & ~gap_means_broadcast);
    nxt_miw = miw_ff;
    if (load) begin
      nxt_miw = WORD_RESET;
      nxt_miw[MIW_GAP_BIT] = gap_or_broadcast_flag;
      nxt_miw[MIW_WCNT_BIT] = word_count_error;
      nxt_miw[MIW_MSGERR_BIT] = message_error_summary;
      nxt_miw[MIW_BUSY_BIT] = replied_busy_flag;
      nxt_miw[MIW_ILL_BIT] = illegal_command_flag;
      nxt_miw[MIW_BUS_BIT] = bus_select_flag;
      nxt_miw[MIW_MC_MSB:0] = mode_code_field;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      miw_ff <= WORD_RESET;
    end else if (ce) begin
      miw_ff <= nxt_miw;
    end
  end

  assign miw = miw_ff;
endmodule

//--- verilog/rtm_pkg.sv
package rtm_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 13;
  localparam int MC_W = 5;
  localparam logic [12:0] OFS_MIW = 13'h0000;
  localparam logic [12:0] OFS_TT = 13'h0001;
  localparam logic [12:0] OFS_DATA = 13'h0002;
  localparam logic [12:0] ADDR_RESET = 13'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam int MIW_GAP_BIT = 13;
  localparam int MIW_WCNT_BIT = 12;
  localparam int MIW_MSGERR_BIT = 10;
  localparam int MIW_BUSY_BIT = 9;
  localparam int MIW_ILL_BIT = 8;
  localparam int MIW_BUS_BIT = 5;
  localparam int MIW_MC_MSB = 4;
  localparam int CMD_TR_BIT = 10;
  localparam int CMD_SA_MSB = 9;
  localparam int CMD_SA_LSB = 5;
  localparam int MC_DATA_BIT = 4;
  localparam logic [4:0] SA_MODE_LO = 5'h00;
  localparam logic [4:0] SA_MODE_HI = 5'h1f;
  localparam logic [4:0] MC_LAST_CMD = 5'h12;
  localparam logic [4:0] MC_BIT_WORD = 5'h13;
  localparam logic [4:0] MC_UNDEF_A = 5'h11;
  localparam logic [4:0] MC_UNDEF_B = 5'h14;
  localparam logic [4:0] MC_UNDEF_C = 5'h15;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [3:0] {
    S_IDLE, S_RDREQ, S_RDWAIT, S_TX, S_WAIT_DONE,
    S_BUILD, S_WR_MIW, S_WR_TT, S_WR_DATA
  } rtm_state_t;
endpackage

//--- verilog/rtm_record.sv
// What this block does
// - Each transmit mode record: info word, time tag, optional data word.
// - Codes 0x12 and 0x13 send an internal word, then store it.
// - Info word at pointer, time tag at pointer plus one, data plus two.
// - Info word and time tag are written only after message completion.
// - Data word is read from the record and sent; internal codes write it.
// - Codes 0x11, 0x14, 0x15 answer normally unless illegal or invalidated.
// - Codes 0x00 to 0x0F store only info word and time tag.
// - With option bit clear, bit 13 flags bus activity where a gap was due.
// - In its other meaning, bit 13 flags a broadcast command.
// - Bit 12 flags unexpected data words with a transmit mode command.
// - Bit 10 summarises the errors of bits 12 and 13.
// - Bit 9 flags a busy reply; no data word is then sent.
// - Bit 8 copies the illegalization table bit of the command.
// - Bit 5 is zero for bus A and one for bus B.
// - Bits 4 to 0 hold the mode code of the command word.
`timescale 1ns/100ps
module rtm_record (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire logic [rtm_pkg::WORD_W-1:0] cmd_word,
  input wire logic cmd_broadcast,
  input wire logic cmd_bus_b,
  input wire logic [rtm_pkg::ADDR_W-1:0] data_ptr,
  input wire logic global_busy,
  input wire logic per_command_busy,
  input wire logic illegal_bit,
  input wire logic undefined_mode_code_invalidate,
  input wire logic gap_means_broadcast,
  input wire logic bus_activity_pin,
  input wire logic response_start,
  input wire logic extra_word,
  input wire logic msg_done,
  input wire logic [rtm_pkg::WORD_W-1:0] last_command,
  input wire logic [rtm_pkg::WORD_W-1:0] bit_word,
  input wire logic [rtm_pkg::WORD_W-1:0] time_tag,
  input wire logic tx_ready,
  input wire logic [rtm_pkg::WORD_W-1:0] ram_rdata,
  output logic tx_valid,
  output logic [rtm_pkg::WORD_W-1:0] tx_data,
  output logic ram_re,
  output logic ram_we,
  output logic [rtm_pkg::ADDR_W-1:0] ram_addr,
  output logic [rtm_pkg::WORD_W-1:0] ram_wdata,
  output logic active,
  output logic record_done
);
  import rtm_pkg::*;
  rtm_state_t st_ff, nxt_st;
  logic [ADDR_W-1:0] ptr_ff, nxt_ptr;
  logic [MC_W-1:0] mc_ff, nxt_mc;
  logic bcast_ff, nxt_bcast;
  logic bus_b_ff, nxt_bus_b;
  logic busy_ff, nxt_busy;
  logic ill_ff, nxt_ill;
  logic gmb_ff, nxt_gmb;
  logic internal_ff, nxt_internal;
  logic sent_ff, nxt_sent;
  logic gap_win_ff, nxt_gap_win;
  logic gap_err_ff, nxt_gap_err;
  logic wc_err_ff, nxt_wc_err;
  logic [WORD_W-1:0] tt_ff, nxt_tt;
  logic [WORD_W-1:0] tx_data_ff, nxt_tx_data;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [WORD_W-1:0] wdata_ff, nxt_wdata;
  logic activity;
  logic is_tx_mode;
  logic accept;
  logic undefined_code;
  logic has_data;
  logic send_data;
  logic build_load;
  logic [WORD_W-1:0] miw;

  rtm_sync u_sync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .async_in(bus_activity_pin),
    .sync_out(activity)
  );

  rtm_miw_build u_build (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .load(build_load),
    .gap_err(gap_err_ff),
    .broadcast(bcast_ff),
    .gap_means_broadcast(gmb_ff),
    .word_count_error(wc_err_ff),
    .replied_busy_flag(busy_ff),
    .illegal_command_flag(ill_ff),
    .bus_select_flag(bus_b_ff),
    .mode_code_field(mc_ff),
    .miw(miw)
  );

  always_comb begin
    is_tx_mode = cmd_word[CMD_TR_BIT]
      & ((cmd_word[CMD_SA_MSB:CMD_SA_LSB] == SA_MODE_LO)
      | (cmd_word[CMD_SA_MSB:CMD_SA_LSB] == SA_MODE_HI));
    accept = (st_ff == S_IDLE) & cmd_valid & is_tx_mode;
    undefined_code = (cmd_word[MIW_MC_MSB:0] == MC_UNDEF_A)
      | (cmd_word[MIW_MC_MSB:0] == MC_UNDEF_B)
      | (cmd_word[MIW_MC_MSB:0] == MC_UNDEF_C);
    has_data = cmd_word[MC_DATA_BIT];
    // Data goes out only for an in-form, non-busy, legal data code.
    send_data = has_data & ~global_busy & ~per_command_busy
      & ~illegal_bit
      & ~(undefined_code & undefined_mode_code_invalidate);
    build_load = msg_done & ((st_ff == S_TX) | (st_ff == S_WAIT_DONE));
    nxt_st = st_ff;
    nxt_ptr = ptr_ff;
    nxt_mc = mc_ff;
    nxt_bcast = bcast_ff;
    nxt_bus_b = bus_b_ff;
    nxt_busy = busy_ff;
    nxt_ill = ill_ff;
    nxt_gmb = gmb_ff;
    nxt_internal = internal_ff;
    nxt_sent = sent_ff;
    nxt_tt = tt_ff;
    nxt_tx_data = tx_data_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_gap_win = (gap_win_ff & ~response_start) | accept;
    nxt_gap_err = (accept ? 1'b0 : gap_err_ff)
      | (gap_win_ff & activity);
    nxt_wc_err = (accept ? 1'b0 : wc_err_ff)
      | ((st_ff != S_IDLE) & extra_word);
    case (st_ff)
      S_IDLE: begin
        if (accept) begin
          nxt_ptr = data_ptr;
          nxt_mc = cmd_word[MIW_MC_MSB:0];
          nxt_bcast = cmd_broadcast;
          nxt_bus_b = cmd_bus_b;
          nxt_busy = global_busy | per_command_busy;
          nxt_ill = illegal_bit;
          nxt_gmb = gap_means_broadcast;
          nxt_sent = 1'b0;
          nxt_internal = (cmd_word[MIW_MC_MSB:0] == MC_LAST_CMD)
            | (cmd_word[MIW_MC_MSB:0] == MC_BIT_WORD);
          if (!send_data) begin
            nxt_st = S_WAIT_DONE;
          end else if (nxt_internal) begin
            nxt_tx_data = (cmd_word[MIW_MC_MSB:0] == MC_LAST_CMD) ?
              last_command : bit_word;
            nxt_st = S_TX;
          end else begin
            nxt_addr = data_ptr + OFS_DATA;
            nxt_st = S_RDREQ;
          end
        end
      end
      S_RDREQ: begin
        nxt_st = S_RDWAIT;
      end
      S_RDWAIT: begin
        nxt_tx_data = ram_rdata;
        nxt_st = S_TX;
      end
      S_TX: begin
        if (msg_done) begin
          nxt_st = S_BUILD;
          nxt_tt = time_tag;
        end else if (tx_ready) begin
          nxt_sent = 1'b1;
          nxt_st = S_WAIT_DONE;
        end
      end
      S_WAIT_DONE: begin
        if (msg_done) begin
          nxt_tt = time_tag;
          nxt_st = S_BUILD;
        end
      end
      S_BUILD: begin
        nxt_addr = ptr_ff + OFS_MIW;
        nxt_wdata = miw;
        nxt_st = S_WR_MIW;
      end
      S_WR_MIW: begin
        nxt_addr = ptr_ff + OFS_TT;
        nxt_wdata = tt_ff;
        nxt_st = S_WR_TT;
      end
      S_WR_TT: begin
        if (internal_ff && sent_ff) begin
          nxt_addr = ptr_ff + OFS_DATA;
          nxt_wdata = tx_data_ff;
          nxt_st = S_WR_DATA;
        end else begin
          nxt_st = S_IDLE;
        end
      end
      S_WR_DATA: begin
        nxt_st = S_IDLE;
      end
      default: begin
        nxt_st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= S_IDLE;
      ptr_ff <= ADDR_RESET;
      mc_ff <= '0;
      bcast_ff <= 1'b0;
      bus_b_ff <= 1'b0;
      busy_ff <= 1'b0;
      ill_ff <= 1'b0;
      gmb_ff <= 1'b0;
      internal_ff <= 1'b0;
      sent_ff <= 1'b0;
      gap_win_ff <= 1'b0;
      gap_err_ff <= 1'b0;
      wc_err_ff <= 1'b0;
      tt_ff <= WORD_RESET;
      tx_data_ff <= WORD_RESET;
      addr_ff <= ADDR_RESET;
      wdata_ff <= WORD_RESET;
    end else if (ce) begin
      st_ff <= nxt_st;
      ptr_ff <= nxt_ptr;
      mc_ff <= nxt_mc;
      bcast_ff <= nxt_bcast;
      bus_b_ff <= nxt_bus_b;
      busy_ff <= nxt_busy;
      ill_ff <= nxt_ill;
      gmb_ff <= nxt_gmb;
      internal_ff <= nxt_internal;
      sent_ff <= nxt_sent;
      gap_win_ff <= nxt_gap_win;
      gap_err_ff <= nxt_gap_err;
      wc_err_ff <= nxt_wc_err;
      tt_ff <= nxt_tt;
      tx_data_ff <= nxt_tx_data;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
    end
  end

  assign tx_valid = (st_ff == S_TX);
  assign tx_data = tx_data_ff;
  assign ram_re = (st_ff == S_RDREQ);
  assign ram_we = (st_ff == S_WR_MIW) | (st_ff == S_WR_TT)
    | (st_ff == S_WR_DATA);
  assign ram_addr = addr_ff;
  assign ram_wdata = wdata_ff;
  assign active = (st_ff != S_IDLE);
  assign record_done = ce & (((st_ff == S_WR_TT) & ~(internal_ff & sent_ff))
    | (st_ff == S_WR_DATA));

  sequence seq_read_slot;
    ram_re && ram_addr == ptr_ff + OFS_DATA;
  endsequence

  sequence seq_send_read;
    ##2 tx_valid && tx_data == $past(ram_rdata);
  endsequence

  sequence seq_completion;
    msg_done && (st_ff == S_WAIT_DONE || st_ff == S_TX);
  endsequence

  AST_READ_THEN_SEND: assert property (@(posedge clk)
    disable iff (reset || !ce) seq_read_slot |-> seq_send_read)
    else $error("Data slot read was not sent two cycles later.");
  AST_WRITE_AFTER_DONE: assert property (@(posedge clk)
    disable iff (reset || !ce) seq_completion |-> ##2 (ram_we
    && ram_addr == ptr_ff && ram_wdata == miw))
    else $error("Info word not written two cycles after completion.");
  AST_TT_FOLLOWS_MIW: assert property (@(posedge clk)
    disable iff (reset || !ce) (st_ff == S_WR_MIW) |=> (ram_we
    && ram_addr == ptr_ff + OFS_TT && ram_wdata == tt_ff))
    else $error("Time tag not written at pointer plus one.");
  AST_MODE_FIELD: assert property (@(posedge clk)
    disable iff (reset || !ce) (st_ff == S_WR_MIW) |->
    (ram_wdata[MIW_MC_MSB:0] == mc_ff
    && ram_wdata[MIW_BUS_BIT] == bus_b_ff))
    else $error("Mode code or bus flag wrong in info word.");
  AST_UNUSED_ZERO: assert property (@(posedge clk)
    disable iff (reset || !ce) (st_ff == S_WR_MIW) |->
    (ram_wdata[15:14] == 2'h0 && !ram_wdata[11]
    && ram_wdata[7:6] == 2'h0))
    else $error("Unused info word bits not zero.");
  AST_SUMMARY: assert property (@(posedge clk)
    disable iff (reset || !ce) (st_ff == S_WR_MIW) |->
    (ram_wdata[MIW_MSGERR_BIT] == (ram_wdata[MIW_WCNT_BIT]
    | (ram_wdata[MIW_GAP_BIT] & !gmb_ff))))
    else $error("Error summary bit does not match error bits.");
  AST_FLAGS: assert property (@(posedge clk)
    disable iff (reset || !ce) (st_ff == S_WR_MIW) |->
    (ram_wdata[MIW_ILL_BIT] == ill_ff
    && ram_wdata[MIW_BUSY_BIT] == busy_ff))
    else $error("Illegal or busy flag wrong in info word.");
  AST_BUSY_NO_DATA: assert property (@(posedge clk)
    disable iff (reset || !ce) busy_ff |-> !tx_valid)
    else $error("Data word sent on a busy reply.");
  AST_NO_DATA_SLOT: assert property (@(posedge clk)
    disable iff (reset || !ce) (ram_we && ram_addr == ptr_ff + OFS_DATA)
    |-> (mc_ff[MC_DATA_BIT] && internal_ff
    && ram_wdata == tx_data_ff && $past(st_ff) == S_WR_TT))
    else $error("Data slot written for a code without internal data.");
  AST_INTERNAL_WORD: assert property (@(posedge clk)
    disable iff (reset || !ce) (accept && send_data
    && cmd_word[MIW_MC_MSB:0] == MC_LAST_CMD) |=>
    (tx_valid && tx_data == $past(last_command)))
    else $error("Last command word not sent.");
endmodule

//--- verilog/rtm_sync.sv
`timescale 1ns/100ps
module rtm_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic async_in,
  output logic sync_out
);
  import rtm_pkg::*;
  logic [SYNC_STAGES-1:0] stage_ff;
  logic [SYNC_STAGES-1:0] nxt_stage;

  // Only the last stage is visible; the first is read by the second alone.
  always_comb begin
    nxt_stage = {stage_ff[SYNC_STAGES-2:0], async_in};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      stage_ff <= '0;
    end else if (ce) begin
      stage_ff <= nxt_stage;
    end
  end

  assign sync_out = stage_ff[SYNC_STAGES-1];
endmodule
